// [ale_pkg.sv]
/*
  Constants, register map and operation codes for the arithmetic/logic
  execution unit. Assumes a single 25 MHz core clock and an APB register bus.
*/
package ale_pkg;

  // ==========================================================================
  // register bus map (byte addresses, one 32-bit word each)
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_EVFLAG   = 8'h08;

  // ==========================================================================
  // field layouts and reset values
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam int          FLG_W         = 6;
  localparam int          FLG_C         = 0;
  localparam int          FLG_Z         = 1;
  localparam int          FLG_N         = 2;
  localparam int          FLG_V         = 3;
  localparam int          FLG_S         = 4;
  localparam int          FLG_H         = 5;
  localparam logic [5:0]  FLG_RST       = 6'h00;
  localparam logic [7:0]  EVFLAG_RST    = 8'h00;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // ==========================================================================
  // data path widths and the low i/o range
  localparam int          BYTE_W        = 8;
  localparam int          WORD_W        = 16;
  localparam int          WIMM_W        = 6;
  localparam int          IO_AW         = 5;
  localparam int          IO_DEPTH      = 32;
  localparam logic [5:0]  IO_LOW_MAX    = 6'h1f;
  localparam logic [4:0]  IO_FLAG_ADDR  = 5'h1c;
  localparam int          SIGN_BIT      = 7;
  localparam int          HALF_BIT      = 3;

  // ==========================================================================
  // operations issued by the decoder
  typedef enum logic [3:0] {
    op_plus_reg_reg,
    op_plus_reg_reg_carry,
    op_word_plus_imm,
    op_minus_reg_reg,
    op_minus_reg_imm,
    op_minus_reg_reg_borrow,
    op_minus_reg_imm_borrow,
    op_word_minus_imm,
    op_bitwise_conj_reg,
    op_bitwise_conj_imm,
    op_io_bit_set,
    op_io_bit_clear,
    op_none
  } ale_op_e;

  typedef enum logic [1:0] {
    st_idle,
    st_word,
    st_io
  } ale_state_e;

endpackage : ale_pkg

// [ale_iomem.sv]
/*
  Byte-wide storage for the low i/o register range.
  Assumes one clock; read data appear one edge after the address.
*/
`timescale 1ns/100ps
module ale_iomem
  import ale_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wr_en,
  input  wire logic [IO_AW-1:0]      wr_addr,
  input  wire logic [BYTE_W-1:0]     wr_data,
  input  wire logic [IO_AW-1:0]      rd_addr,
  output logic      [BYTE_W-1:0]     rd_data
);
  import ale_pkg::*;

  logic [BYTE_W-1:0] mem [IO_DEPTH];

  // ==========================================================================
  // storage, no reset so it maps onto plain ram
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ==========================================================================
  // registered read port
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : ale_iomem

// [ale_exec.sv]
/*
  Execution unit for byte add/subtract/and, word add/subtract with a small
  constant, and read-modify-write bit set/clear in the low i/o range.
  Assumes the decoder and register file on the same clock supply operand
  values and take back the result; software reaches control over APB.
*/
// The register addresses and the APB register port were left to the implementer.
// Overview of operation
// [RQ1] add registers, optional carry; ZCNVH; one clock
// [RQ2] word plus constant; ZCNVS; two clocks
// [RQ3] subtract registers; ZCNVH; one clock
// [RQ4] subtract constant; ZCNVH; one clock
// [RQ5] subtract register and carry; ZCNVH; one clock
// [RQ6] subtract constant and carry; ZCNVH; one clock
// [RQ7] word minus constant; ZCNVS; two clocks
// [RQ8] and registers; ZNV only; one clock
// [RQ9] and constant; ZNV only; one clock
// [RQ10] bit ops rewrite the whole i/o byte
// [RQ11] bit ops reach addresses 0x00-0x1f only
// [RQ12] status flags clear on writing one; the code loads status from the write data
// [RQ13] software writes reserved bits as zero
// [RQ14] and-type ops clear overflow flag
`timescale 1ns/100ps
module ale_exec
  import ale_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  op_valid,
  input  wire ale_pkg::ale_op_e      op_code,
  input  wire logic [BYTE_W-1:0]     op_dest_val,
  input  wire logic [BYTE_W-1:0]     op_src_val,
  input  wire logic [BYTE_W-1:0]     op_imm,
  input  wire logic [WORD_W-1:0]     op_pair_val,
  input  wire logic [5:0]            op_io_addr,
  input  wire logic [2:0]            op_bit,
  output logic                       op_ready,
  output logic                       wb_valid,
  output logic      [BYTE_W-1:0]     wb_byte,
  output logic      [WORD_W-1:0]     wb_word,
  output logic                       wb_is_word,
  output logic      [FLG_W-1:0]      status_flags,
  output logic                       io_done,
  output logic                       io_reject,
  input  wire logic [BYTE_W-1:0]     io_event,
  output logic      [BYTE_W-1:0]     ev_flags
);
  import ale_pkg::*;

  ale_state_e           state;
  logic                 ctrl_en;
  logic                 accept;
  logic                 apb_wr;
  logic                 hit;
  logic                 word_sub;
  logic [WORD_W-1:0]    word_opnd;
  logic [WIMM_W-1:0]    word_k;
  logic [IO_AW-1:0]     io_addr;
  logic [2:0]           io_bit;
  logic                 io_set;
  logic [BYTE_W-1:0]    mem_rdata;
  logic [BYTE_W-1:0]    io_cur;
  logic [BYTE_W-1:0]    io_new;
  logic                 io_to_flag;
  logic [BYTE_W-1:0]    ev_clr;
  logic                 byte_op;
  logic [BYTE_W-1:0]    next_byte;
  logic [FLG_W-1:0]     next_flags;
  logic [WORD_W-1:0]    next_word;
  logic [FLG_W-1:0]     next_wflags;

  // ==========================================================================
  // handshakes
  assign op_ready = ctrl_en && (state == st_idle);
  assign accept   = op_valid && op_ready;
  assign apb_wr   = psel && penable && pwrite;
  assign hit      = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_EVFLAG);
  // zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  // ==========================================================================
  // byte alu, evaluated on the issue cycle
  always_comb begin
    logic [BYTE_W-1:0] a;
    logic [BYTE_W-1:0] b;
    logic [BYTE_W-1:0] r;
    logic              cin;
    logic              cout;
    a          = op_dest_val;
    b          = op_src_val;
    r          = '0;
    cin        = 1'b0;
    cout       = 1'b0;
    byte_op    = 1'b1;
    next_flags = status_flags;
    case (op_code)
      op_plus_reg_reg, op_plus_reg_reg_carry: begin
        // [RQ1] sum with optional carry in
        cin       = (op_code == op_plus_reg_reg_carry) ? status_flags[FLG_C] : 1'b0;
        {cout, r} = 9'(a) + 9'(b) + 9'(cin);
        next_flags[FLG_C] = cout;
        next_flags[FLG_H] = (a[HALF_BIT] & b[HALF_BIT]) | (b[HALF_BIT] & ~r[HALF_BIT]) |
                            (~r[HALF_BIT] & a[HALF_BIT]);
        next_flags[FLG_V] = (a[SIGN_BIT] & b[SIGN_BIT] & ~r[SIGN_BIT]) |
                            (~a[SIGN_BIT] & ~b[SIGN_BIT] & r[SIGN_BIT]);
      end
      op_minus_reg_reg, op_minus_reg_imm, op_minus_reg_reg_borrow,
      op_minus_reg_imm_borrow: begin
        // [RQ3] [RQ4] register or constant subtrahend
        if ((op_code == op_minus_reg_imm) || (op_code == op_minus_reg_imm_borrow)) begin
          b = op_imm;
        end
        // [RQ5] [RQ6] carry acts as borrow in
        if ((op_code == op_minus_reg_reg_borrow) || (op_code == op_minus_reg_imm_borrow)) begin
          cin = status_flags[FLG_C];
        end
        r = a - b - BYTE_W'(cin);
        next_flags[FLG_C] = (~a[SIGN_BIT] & b[SIGN_BIT]) | (b[SIGN_BIT] & r[SIGN_BIT]) |
                            (r[SIGN_BIT] & ~a[SIGN_BIT]);
        next_flags[FLG_H] = (~a[HALF_BIT] & b[HALF_BIT]) | (b[HALF_BIT] & r[HALF_BIT]) |
                            (r[HALF_BIT] & ~a[HALF_BIT]);
        next_flags[FLG_V] = (a[SIGN_BIT] & ~b[SIGN_BIT] & ~r[SIGN_BIT]) |
                            (~a[SIGN_BIT] & b[SIGN_BIT] & r[SIGN_BIT]);
      end
      op_bitwise_conj_reg, op_bitwise_conj_imm: begin
        // [RQ8] [RQ9] carry and half-carry left alone
        if (op_code == op_bitwise_conj_imm) begin
          b = op_imm;
        end
        r = a & b;
        // [RQ14] overflow forced low
        next_flags[FLG_V] = 1'b0;
      end
      default: begin
        byte_op = 1'b0;
      end
    endcase
    if (byte_op) begin
      next_flags[FLG_Z] = (r == '0);
      next_flags[FLG_N] = r[SIGN_BIT];
    end
    next_byte = r;
  end

  // ==========================================================================
  // word alu, evaluated in the second cycle from latched operands
  always_comb begin
    logic p15;
    logic r15;
    p15         = word_opnd[WORD_W-1];
    r15         = 1'b0;
    next_wflags = status_flags;
    if (word_sub) begin
      next_word = word_opnd - WORD_W'(word_k);
    end else begin
      next_word = word_opnd + WORD_W'(word_k);
    end
    r15 = next_word[WORD_W-1];
    // [RQ2] [RQ7] word flags, half-carry untouched
    next_wflags[FLG_V] = word_sub ? (p15 & ~r15) : (~p15 & r15);
    next_wflags[FLG_C] = word_sub ? (r15 & ~p15) : (~r15 & p15);
    next_wflags[FLG_N] = r15;
    next_wflags[FLG_Z] = (next_word == '0);
    next_wflags[FLG_S] = r15 ^ next_wflags[FLG_V];
  end

  // ==========================================================================
  // sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (accept && ((op_code == op_word_plus_imm) || (op_code == op_word_minus_imm))) begin
            // [RQ2] [RQ7] second clock for the word ops
            state <= st_word;
          end else if (accept && ((op_code == op_io_bit_set) || (op_code == op_io_bit_clear)) &&
                       (op_io_addr <= IO_LOW_MAX)) begin
            state <= st_io;
          end
        end
        st_word: begin
          state <= st_idle;
        end
        st_io: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ==========================================================================
  // operand capture for multi-cycle ops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      word_sub  <= 1'b0;
      word_opnd <= '0;
      word_k    <= '0;
      io_addr   <= '0;
      io_bit    <= '0;
      io_set    <= 1'b0;
    end else if (accept) begin
      word_sub  <= (op_code == op_word_minus_imm);
      word_opnd <= op_pair_val;
      word_k    <= op_imm[WIMM_W-1:0];
      io_addr   <= op_io_addr[IO_AW-1:0];
      io_bit    <= op_bit;
      io_set    <= (op_code == op_io_bit_set);
    end
  end

  // ==========================================================================
  // write-back to the register file
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_valid   <= 1'b0;
      wb_byte    <= '0;
      wb_word    <= '0;
      wb_is_word <= 1'b0;
    end else begin
      wb_valid   <= 1'b0;
      wb_is_word <= 1'b0;
      if (accept && byte_op) begin
        // [RQ1] [RQ3] [RQ8] single-clock result
        wb_valid <= 1'b1;
        wb_byte  <= next_byte;
      end else if (state == st_word) begin
        // [RQ2] [RQ7] pair written back whole
        wb_valid   <= 1'b1;
        wb_is_word <= 1'b1;
        wb_word    <= next_word;
      end
    end
  end

  // ==========================================================================
  // status flags; the alu update beats a same-cycle bus write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_flags <= FLG_RST;
    end else if (accept && byte_op) begin
      status_flags <= next_flags;
    end else if (state == st_word) begin
      status_flags <= next_wflags;
    end else if (apb_wr && (paddr == ADDR_STATUS)) begin
      status_flags <= pwdata[FLG_W-1:0];
    end
  end

  // ==========================================================================
  // control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_en <= CTRL_EN_RST;
    end else if (apb_wr && (paddr == ADDR_CTRL)) begin
      ctrl_en <= pwdata[CTRL_EN_BIT];
    end
  end

  // ==========================================================================
  // i/o read-modify-write
  ale_iomem u_iomem (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_en   ((state == st_io) && !io_to_flag),
    .wr_addr (io_addr),
    .wr_data (io_new),
    .rd_addr (op_io_addr[IO_AW-1:0]),
    .rd_data (mem_rdata)
  );

  assign io_to_flag = (io_addr == IO_FLAG_ADDR);
  assign io_cur     = io_to_flag ? ev_flags : mem_rdata;

  // [RQ10] whole byte rewritten, set flags echo back as ones
  always_comb begin
    io_new = io_cur;
    io_new[io_bit] = io_set;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      io_done   <= 1'b0;
      io_reject <= 1'b0;
    end else begin
      io_done   <= (state == st_io);
      // [RQ11] upper addresses never touched
      io_reject <= accept && ((op_code == op_io_bit_set) || (op_code == op_io_bit_clear)) &&
                   (op_io_addr > IO_LOW_MAX);
    end
  end

  // ==========================================================================
  // write-one-to-clear event flags
  always_comb begin
    ev_clr = '0;
    if (apb_wr && (paddr == ADDR_EVFLAG)) begin
      ev_clr = ev_clr | pwdata[BYTE_W-1:0];
    end
    if ((state == st_io) && io_to_flag) begin
      ev_clr = ev_clr | io_new;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BYTE_W; gi++) begin : g_evflag
      // [RQ12] one clears, zero keeps; a new event beats the clear
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          ev_flags[gi] <= EVFLAG_RST[gi];
        end else if (io_event[gi]) begin
          ev_flags[gi] <= 1'b1;
        end else if (ev_clr[gi]) begin
          ev_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read data, captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= RDATA_ZERO;
    end else if (psel && !penable && !pwrite) begin
      // [RQ13] reserved bits read as zero
      case (paddr)
        ADDR_CTRL:   prdata <= {31'h0, ctrl_en};
        ADDR_STATUS: prdata <= {26'h0, status_flags};
        ADDR_EVFLAG: prdata <= {24'h0, ev_flags};
        default:     prdata <= RDATA_ZERO;
      endcase
    end
  end

endmodule : ale_exec

// [ale_exec_chk.sv]
/* Port checker for the execution unit: timing, results and flags.
   Bound to ale_exec; one clock, synchronous active-high reset. */
`timescale 1ns/100ps
module ale_exec_chk
  import ale_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             sys_rst,
  input wire logic             op_valid,
  input wire ale_pkg::ale_op_e op_code,
  input wire logic [7:0]       op_dest_val,
  input wire logic [7:0]       op_src_val,
  input wire logic [5:0]       op_io_addr,
  input wire logic             op_ready,
  input wire logic             wb_valid,
  input wire logic [7:0]       wb_byte,
  input wire logic [15:0]      wb_word,
  input wire logic             wb_is_word,
  input wire logic [5:0]       status_flags,
  input wire logic             io_done,
  input wire logic             io_reject
);
  import ale_pkg::*;
  // ========
  // request classes
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic acc, is_w, is_io, is_and, is_b;
  assign acc = op_valid && op_ready;
  assign is_w = op_code inside {op_word_plus_imm, op_word_minus_imm};
  assign is_io = op_code inside {op_io_bit_set, op_io_bit_clear};
  assign is_and = op_code inside {op_bitwise_conj_reg, op_bitwise_conj_imm};
  assign is_b = !is_w && !is_io && op_code != op_none;
  // ========
  // assertions
  a_byte_lat: assert property (acc && is_b |=> wb_valid && !wb_is_word)
    else $error("byte op result not one edge after accept");
  a_word_lat: assert property (acc && is_w |=>
    !op_ready && !wb_valid ##1 wb_valid && wb_is_word)
    else $error("word op result not two edges after accept");
  a_io_done: assert property (acc && is_io && op_io_addr <= IO_LOW_MAX |=>
    !io_reject ##1 io_done)
    else $error("bit op in low range did not finish");
  a_io_far: assert property (acc && is_io && op_io_addr > IO_LOW_MAX |=>
    io_reject ##1 !io_done)
    else $error("bit op above low range not refused");
  a_and_keep: assert property (acc && is_and |=> !status_flags[FLG_V]
    && status_flags[FLG_C] == $past(status_flags[FLG_C])
    && status_flags[FLG_H] == $past(status_flags[FLG_H]))
    else $error("and op flag update wrong");
  a_add_sum: assert property (acc && op_code == op_plus_reg_reg |=>
    wb_byte == 8'($past(op_dest_val) + $past(op_src_val)))
    else $error("register add result wrong");
  a_sub_diff: assert property (acc && op_code == op_minus_reg_reg |=>
    wb_byte == 8'($past(op_dest_val) - $past(op_src_val)))
    else $error("register subtract result wrong");
  a_zero_flag: assert property (wb_valid |-> status_flags[FLG_Z] ==
    (wb_is_word ? wb_word == 16'h0 : wb_byte == 8'h0))
    else $error("zero flag does not match result");
  a_word_sign: assert property (wb_valid && wb_is_word |->
    status_flags[FLG_N] == wb_word[15]
    && status_flags[FLG_S] == (wb_word[15] ^ status_flags[FLG_V]))
    else $error("word sign flags wrong");
  c_word: cover property (acc && is_w);
  c_far: cover property (io_reject);
  c_ovf: cover property (wb_valid && status_flags[FLG_V]);
endmodule : ale_exec_chk

bind ale_exec ale_exec_chk i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .op_dest_val(op_dest_val), .op_src_val(op_src_val),
  .op_io_addr(op_io_addr), .op_ready(op_ready), .wb_valid(wb_valid), .wb_byte(wb_byte),
  .wb_word(wb_word), .wb_is_word(wb_is_word), .status_flags(status_flags),
  .io_done(io_done), .io_reject(io_reject));

// [ale_dec_model.sv]
/* Decoder and register file model issuing operations to the unit.
   Shares the unit's clock; callers enter put right after a rising edge. */
`timescale 1ns/100ps
module ale_dec_model
  import ale_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         op_ready,
  output logic             op_valid,
  output ale_pkg::ale_op_e op_code,
  output logic [7:0]       op_dest_val,
  output logic [7:0]       op_src_val,
  output logic [7:0]       op_imm,
  output logic [15:0]      op_pair_val,
  output logic [5:0]       op_io_addr,
  output logic [2:0]       op_bit
);
  initial begin
    {op_valid, op_dest_val, op_src_val, op_imm, op_pair_val, op_io_addr, op_bit} = '0;
    op_code = op_none;
  end
  // held until taken; left raised so requests can follow back to back
  task automatic put(input ale_op_e c, input logic [7:0] d, k, input logic [15:0] p,
                     input logic [5:0] a, input logic [2:0] b);
    op_valid <= 1'b1;
    op_code <= c;
    op_dest_val <= d;
    op_src_val <= k;
    op_imm <= k;
    op_pair_val <= p;
    op_io_addr <= a;
    op_bit <= b;
    @(posedge ref_clk);
    while (op_ready !== 1'b1) @(posedge ref_clk);
  endtask : put
  // released register operands flip so stale values cannot pass for fresh ones; op_imm keeps its value
  task automatic stop;
    op_valid <= 1'b0;
    op_dest_val <= ~op_dest_val;
    op_src_val <= ~op_src_val;
    op_pair_val <= ~op_pair_val;
  endtask : stop
endmodule : ale_dec_model

// [test_arith_logic_exec_unit.sv]
/* Self-checking bench for the execution unit, with a decoder model.
   Assumes ale_pkg, ale_exec and the bound checker are compiled first. */
`timescale 1ns/100ps
module test_arith_logic_exec_unit;
  import ale_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, io_event, ev_flags, op_dest_val, op_src_val, op_imm, wb_byte;
  logic [31:0] pwdata, prdata;
  logic op_valid, op_ready, wb_valid, wb_is_word, io_done, io_reject;
  ale_op_e op_code;
  logic [15:0] op_pair_val, wb_word;
  logic [5:0] op_io_addr, status_flags, flg;
  logic [2:0] op_bit;
  int n_errors, tests_run;

  ale_exec i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_dest_val(op_dest_val),
    .op_src_val(op_src_val), .op_imm(op_imm), .op_pair_val(op_pair_val),
    .op_io_addr(op_io_addr), .op_bit(op_bit), .op_ready(op_ready), .wb_valid(wb_valid),
    .wb_byte(wb_byte), .wb_word(wb_word), .wb_is_word(wb_is_word),
    .status_flags(status_flags), .io_done(io_done), .io_reject(io_reject),
    .io_event(io_event), .ev_flags(ev_flags));
  ale_dec_model i_dec (.ref_clk(ref_clk), .op_ready(op_ready), .op_valid(op_valid),
    .op_code(op_code), .op_dest_val(op_dest_val), .op_src_val(op_src_val), .op_imm(op_imm),
    .op_pair_val(op_pair_val), .op_io_addr(op_io_addr), .op_bit(op_bit));

  // ========
  // helpers
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // flags and results worked out from operands and the incoming flags
  function automatic logic [29:0] ref_op(input ale_op_e o, input logic [7:0] d, k,
                                         input logic [15:0] p, input logic [5:0] f);
    logic [8:0] r;
    logic [4:0] h;
    logic [16:0] w;
    logic c, s;
    c = (o inside {op_plus_reg_reg_carry, op_minus_reg_reg_borrow,
                   op_minus_reg_imm_borrow}) & f[FLG_C];
    s = o inside {op_minus_reg_reg, op_minus_reg_imm, op_minus_reg_reg_borrow,
                  op_minus_reg_imm_borrow};
    r = s ? {1'b0, d} - k - c : {1'b0, d} + k + c;
    h = s ? {1'b0, d[3:0]} - k[3:0] - c : {1'b0, d[3:0]} + k[3:0] + c;
    w = o == op_word_minus_imm ? {1'b0, p} - k[5:0] : {1'b0, p} + k[5:0];
    if (o inside {op_word_plus_imm, op_word_minus_imm}) begin
      f[FLG_C] = w[16];
      f[FLG_Z] = w[15:0] == 16'h0;
      f[FLG_N] = w[15];
      f[FLG_V] = o == op_word_minus_imm ? p[15] & ~w[15] : ~p[15] & w[15];
      f[FLG_S] = w[15] ^ f[FLG_V];
      return {f, w[15:0], 8'h0};
    end
    if (o inside {op_bitwise_conj_reg, op_bitwise_conj_imm}) begin
      r = {1'b0, d & k};
      f[FLG_V] = 1'b0;
    end else begin
      f[FLG_C] = r[8];
      f[FLG_H] = h[4];
      f[FLG_V] = s ? (d[7] ^ k[7]) & (d[7] ^ r[7]) : ~(d[7] ^ k[7]) & (d[7] ^ r[7]);
    end
    f[FLG_Z] = r[7:0] == 8'h0;
    f[FLG_N] = r[7];
    return {f, 16'h0, r[7:0]};
  endfunction : ref_op
  task automatic do_op(input ale_op_e o, input logic [7:0] d, k, input logic [15:0] p);
    logic [29:0] e;
    logic w;
    e = ref_op(o, d, k, p, flg);
    w = o inside {op_word_plus_imm, op_word_minus_imm};
    i_dec.put(o, d, k, p, 6'h0, 3'h0);
    i_dec.stop();
    @(posedge ref_clk);
    if (w) begin
      chk(op_ready, 0);
      @(posedge ref_clk);
    end
    chk(wb_valid, 1);
    chk(wb_is_word, w);
    chk(w ? wb_word : wb_byte, w ? e[23:8] : e[7:0]);
    chk(status_flags, e[29:24]);
    flg = e[29:24];
  endtask : do_op
  task automatic do_io(input ale_op_e c, input logic [5:0] a, input logic [2:0] b,
                       input logic rej);
    i_dec.put(c, 8'h0, 8'h0, 16'h0, a, b);
    i_dec.stop();
    @(posedge ref_clk);
    chk(io_reject, rej);
    @(posedge ref_clk);
    chk(io_done, !rej);
    @(posedge ref_clk);
  endtask : do_io
  task automatic ev_pulse(input logic [7:0] v);
    io_event <= v;
    @(posedge ref_clk);
    io_event <= 8'h0;
    @(posedge ref_clk);
  endtask : ev_pulse

  // ========
  // scenarios
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    chk(status_flags, 0);
    apb(1'b0, ADDR_CTRL, 0, q, e);
    chk(q, 1);
    apb(1'b1, 8'h0c, 32'h3f, q, e);
    chk(e, 1);
    apb(1'b1, ADDR_CTRL, 32'h0, q, e);
    chk(op_ready, 0);
    apb(1'b1, ADDR_CTRL, 32'h1, q, e);
    apb(1'b1, ADDR_STATUS, 32'h21, q, e);
    apb(1'b0, ADDR_STATUS, 0, q, e);
    chk(q, 32'h21);
    flg = 6'h21;
    $display("test regs done");
  endtask : t_regs
  task automatic t_alu;
    ale_op_e o[12] = '{op_plus_reg_reg_carry, op_minus_reg_reg, op_minus_reg_reg_borrow,
      op_minus_reg_imm, op_minus_reg_imm_borrow, op_plus_reg_reg, op_bitwise_conj_reg,
      op_bitwise_conj_imm, op_word_plus_imm, op_word_minus_imm, op_word_plus_imm,
      op_word_minus_imm};
    logic [31:0] v[12] = '{32'hff00_0000, 32'h0001_0000, 32'h100f_0000, 32'h0001_0000,
      32'h0504_0000, 32'h7f01_0000, 32'hf00f_0000, 32'h80ff_0000, 32'h003f_00ff,
      32'h0001_0000, 32'h0010_fff0, 32'h0001_8000};
    foreach (o[i]) do_op(o[i], v[i][31:24], v[i][23:16], v[i][15:0]);
    $display("test alu done");
  endtask : t_alu
  task automatic t_b2b;
    logic [29:0] e1, e2;
    e1 = ref_op(op_minus_reg_reg, 8'h0, 8'h0, 16'h0, flg);
    e2 = ref_op(op_plus_reg_reg_carry, 8'hff, 8'h01, 16'h0, e1[29:24]);
    i_dec.put(op_minus_reg_reg, 8'h0, 8'h0, 16'h0, 6'h0, 3'h0);
    i_dec.put(op_plus_reg_reg_carry, 8'hff, 8'h01, 16'h0, 6'h0, 3'h0);
    chk(status_flags, e1[29:24]);
    i_dec.stop();
    @(posedge ref_clk);
    chk(wb_byte, e2[7:0]);
    chk(status_flags, e2[29:24]);
    flg = e2[29:24];
    $display("test b2b done");
  endtask : t_b2b
  task automatic t_io;
    logic [31:0] q;
    logic e;
    ev_pulse(8'h09);
    chk(ev_flags, 8'h09);
    do_io(op_io_bit_set, 6'h3c, 3'h5, 1'b1);
    chk(ev_flags, 8'h09);
    do_io(op_io_bit_set, {1'b0, IO_FLAG_ADDR}, 3'h5, 1'b0);
    chk(ev_flags, 8'h00);
    ev_pulse(8'h30);
    do_io(op_io_bit_clear, {1'b0, IO_FLAG_ADDR}, 3'h4, 1'b0);
    chk(ev_flags, 8'h10);
    apb(1'b1, ADDR_EVFLAG, 32'h0, q, e);
    chk(ev_flags, 8'h10);
    apb(1'b1, ADDR_EVFLAG, 32'h10, q, e);
    chk(ev_flags, 8'h00);
    do_io(op_io_bit_clear, 6'h1f, 3'h0, 1'b0);
    do_io(op_io_bit_clear, 6'h20, 3'h0, 1'b1);
    $display("test io done");
  endtask : t_io

  // ========
  // clock, reset, sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, io_event} = '0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_regs();
    t_alu();
    t_b2b();
    t_io();
    complete_run();
  end
  // whole run needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
endmodule : test_arith_logic_exec_unit
